/* rtl/odic_regs.svh */
// constants for the oversampled digital input capture block
`ifndef ODIC_REGS_SVH
`define ODIC_REGS_SVH

// ****************************************************************
// channel and image sizing
// ****************************************************************
`define ODIC_CHANNELS 2
`define ODIC_IMAGE_BYTES 254
`define ODIC_MAX_BLOCKS 254
`define ODIC_BLOCK_PAD_W 6

// ****************************************************************
// timing
// ****************************************************************
`define ODIC_CLK_PERIOD_NS 50
`define ODIC_MIN_INTERVAL_NS 1000
`define ODIC_MIN_INTERVAL_CYC \
  ((`ODIC_MIN_INTERVAL_NS + `ODIC_CLK_PERIOD_NS - 1) / `ODIC_CLK_PERIOD_NS)

// ****************************************************************
// reset values
// ****************************************************************
`define ODIC_RST_BYTE 8'h00
`define ODIC_RST_WORD 32'h0000_0000

`endif

/* rtl/odic_pkg.sv */
// types shared by the capture block modules
package odic_pkg;

  typedef enum logic [1:0] {
    ODIC_ST_WAIT = 2'b01,
    ODIC_ST_RUN = 2'b10
  } odic_state_e;

  typedef enum logic [1:0] {
    ODIC_SMP_IDLE = 2'b01,
    ODIC_SMP_ARMED = 2'b10
  } odic_smp_state_e;

endpackage

/* rtl/odic_smp_if.sv */
// sample strobe carrier between the sampler and the capture top
`timescale 1ns/1ps
interface odic_smp_if;
  logic strobe;
  logic [1:0] sample;
  logic [7:0] index;

  modport src (output strobe, output sample, output index);
  modport dst (input strobe, input sample, input index);
endinterface

/* rtl/odic_sampler.sv */
// equidistant sub-cycle sampler locked to the distributed clock time
`timescale 1ns/1ps
`include "odic_regs.svh"
module odic_sampler
  import odic_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // field inputs and time base
  input wire logic [1:0] chan_in,
  input wire logic [31:0] dc_time_in,
  // control from the capture top
  input wire logic start_in,
  input wire logic [7:0] factor_in,
  input wire logic [31:0] period_in,
  // sample strobes out
  odic_smp_if.src smp
);

  typedef struct packed {
    odic_smp_state_e st;
    logic [31:0] target;
    logic [7:0] count;
    logic strobe;
    logic [1:0] sample;
    logic [7:0] index;
  } odic_smp_s;

  odic_smp_s r;
  odic_smp_s next_r;
  logic due;

  // wrap-safe compare so the time base may roll over mid-cycle
  assign due = ($signed(dc_time_in - r.target) >= 0);

  always_comb begin
    next_r = r;
    next_r.strobe = 1'b0;
    case (r.st)
      ODIC_SMP_IDLE: begin
      end
      ODIC_SMP_ARMED: begin
        if (r.count == factor_in) begin
          next_r.st = ODIC_SMP_IDLE;
        end else if (due) begin
          next_r.strobe = 1'b1;
          next_r.sample = chan_in;
          next_r.index = r.count;
          next_r.count = r.count + 8'h01;
          next_r.target = r.target + period_in;
        end
      end
      default: begin
        next_r.st = ODIC_SMP_IDLE;
      end
    endcase
    // a new bus cycle restarts the grid at the sync instant itself
    if (start_in) begin
      next_r.st = ODIC_SMP_ARMED;
      next_r.count = 8'h00;
      next_r.target = dc_time_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '{st: ODIC_SMP_IDLE, target: `ODIC_RST_WORD, count: `ODIC_RST_BYTE,
             strobe: 1'b0, sample: 2'b00, index: `ODIC_RST_BYTE};
    end else begin
      r <= next_r;
    end
  end

  assign smp.strobe = r.strobe;
  assign smp.sample = r.sample;
  assign smp.index = r.index;

endmodule // odic_sampler

/* rtl/odic_capture_top.sv */
// two-channel oversampled input capture with double-banked sample sets
`timescale 1ns/1ps
`include "odic_regs.svh"

// Notes on behaviour
// - two independent inputs captured every sample instant
// - n sub-cycle samples per bus cycle
// - one block per sub-cycle, set sent next cycle
// - sample grid taken from distributed clock time
// - equidistant reads, stored until collected
// - finished set complete before any fetch
// - image at most 254 bytes, n limited
module odic_capture_top
  import odic_pkg::*;
#(
  parameter int unsigned MAX_BLOCKS = `ODIC_MAX_BLOCKS,
  parameter int unsigned MIN_INTERVAL_NS = `ODIC_MIN_INTERVAL_NS
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // field inputs
  input wire logic [1:0] chan_in,
  // distributed clock time base
  input wire logic [31:0] dc_time_in,
  input wire logic dc_sync_in,
  // configuration
  input wire logic [9:0] os_factor_in,
  input wire logic [31:0] sub_period_in,
  // fetch port from the fieldbus slave controller
  input wire logic fetch_req_in,
  input wire logic [7:0] fetch_addr_in,
  output logic [7:0] fetch_data_out,
  output logic fetch_valid_out,
  // set status
  output logic set_ready_out,
  output logic [7:0] set_blocks_out,
  output logic set_short_out,
  output logic [7:0] short_count_out,
  output logic cfg_err_out,
  output logic running_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    odic_state_e st;
    logic [1:0][MAX_BLOCKS-1:0][1:0] mem;
    logic act;
    logic [7:0] fill;
    logic [7:0] rdy_blocks;
    logic rdy_valid;
    logic short_set;
    logic [7:0] short_count;
    logic [7:0] n;
    logic [31:0] period;
    logic cfg_err;
    logic [7:0] fdata;
    logic fvalid;
  } odic_top_s;

  odic_top_s r;
  odic_top_s next_r;
  logic cfg_bad;
  logic start;
  logic [7:0] fill_now;
  localparam int unsigned CHANNELS = `ODIC_CHANNELS;

  logic factor_zero;
  logic factor_big;
  logic period_short;
  logic take;
  logic [1:0] sealed_blk;
  logic [7:0] sealed_byte;

  odic_smp_if smp_bus ();

  // ****************************************************************
  // helpers
  // ****************************************************************
  // true when a byte index lands inside a set of the given length
  function automatic logic blk_hit(input logic [7:0] addr, input logic [7:0] blocks);
    blk_hit = (addr < blocks);
  endfunction

  // ****************************************************************
  // configuration check
  // ****************************************************************
  assign factor_zero = (os_factor_in == 10'h000);
  // one byte per block, so n is capped at the image size
  assign factor_big = ({22'h00_0000, os_factor_in} > MAX_BLOCKS);
  assign period_short = (sub_period_in < MIN_INTERVAL_NS);
  assign cfg_bad = factor_zero || factor_big || period_short;

  // refused settings never start or restart the sampler, so no refused grid can overrun the image
  assign start = dc_sync_in && !cfg_bad;

  // ****************************************************************
  // strobe intake
  // ****************************************************************
  // strobes from a grid that a refused sync abandoned are dropped,
  // so a later restart never inherits stale blocks
  assign take = smp_bus.strobe && (r.st == ODIC_ST_RUN) &&
                blk_hit(smp_bus.index, 8'(MAX_BLOCKS));

  // ****************************************************************
  // sampler
  // ****************************************************************
  // factor and period follow the value latched on this edge, so a restart and its grid agree
  odic_sampler u_sampler (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .chan_in(chan_in),
    .dc_time_in(dc_time_in),
    .start_in(start),
    .factor_in(next_r.n),
    .period_in(next_r.period),
    .smp(smp_bus.src)
  );

  // ****************************************************************
  // fetch byte assembly
  // ****************************************************************
  // index bounded first so a fetch past the set never reads beyond the bank
  assign sealed_blk = blk_hit(fetch_addr_in, r.rdy_blocks) ?
                      r.mem[~r.act][fetch_addr_in] : 2'b00;

  // bit k of a block carries channel k, the spare upper bits read as zero
  for (genvar b = 0; b < 8; b++) begin : g_fetch_bit
    if (b < CHANNELS) begin : g_chan
      assign sealed_byte[b] = sealed_blk[b];
    end else begin : g_pad
      assign sealed_byte[b] = 1'b0;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_r = r;
    next_r.fvalid = 1'b0;
    fill_now = r.fill;

    // a strobe in the sync cycle still belongs to the bank being sealed
    if (take) begin
      next_r.mem[r.act][smp_bus.index] = smp_bus.sample;
      fill_now = smp_bus.index + 8'h01;
    end
    next_r.fill = fill_now;

    case (r.st)
      ODIC_ST_WAIT: begin
        if (dc_sync_in) begin
          next_r.cfg_err = cfg_bad;
        end
        if (start) begin
          next_r.st = ODIC_ST_RUN;
          next_r.fill = 8'h00;
          next_r.n = os_factor_in[7:0];
          next_r.period = sub_period_in;
        end
      end
      ODIC_ST_RUN: begin
        if (dc_sync_in) begin
          // seal the finished cycle and flip banks in one edge
          next_r.rdy_blocks = fill_now;
          next_r.rdy_valid = (fill_now == r.n);
          next_r.short_set = (fill_now != r.n);
          if ((fill_now != r.n) && (r.short_count != 8'hff)) begin
            next_r.short_count = r.short_count + 8'h01;
          end
          next_r.act = ~r.act;
          next_r.fill = 8'h00;
          next_r.cfg_err = cfg_bad;
          // a refused config still seals the cycle that just ended
          if (cfg_bad) begin
            next_r.st = ODIC_ST_WAIT;
          end else begin
            next_r.n = os_factor_in[7:0];
            next_r.period = sub_period_in;
          end
        end
      end
      default: begin
        next_r.st = ODIC_ST_WAIT;
      end
    endcase

    // fetches read only the sealed bank, never the one being filled
    if (fetch_req_in) begin
      next_r.fvalid = 1'b1;
      next_r.fdata = sealed_byte;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '0;
      r.st <= ODIC_ST_WAIT;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign fetch_data_out = r.fdata;
  assign fetch_valid_out = r.fvalid;
  assign set_ready_out = r.rdy_valid;
  assign set_blocks_out = r.rdy_blocks;
  assign set_short_out = r.short_set;
  assign short_count_out = r.short_count;
  assign cfg_err_out = r.cfg_err;
  assign running_out = (r.st == ODIC_ST_RUN);

endmodule // odic_capture_top

/* tb/odic_capture_top_sva.sv */
// port assertions for the capture block
`timescale 1ns/1ps
module odic_chk #(
  parameter int unsigned MAX_BLOCKS = 254
) (
  // clock and reset
  input logic core_clk_in,
  input logic rst_in,
  // watched ports
  input logic dc_sync_in,
  input logic [9:0] os_factor_in,
  input logic fetch_req_in,
  input logic [7:0] fetch_addr_in,
  input logic [7:0] fetch_data_out,
  input logic fetch_valid_out,
  input logic set_ready_out,
  input logic set_short_out,
  input logic [7:0] set_blocks_out,
  input logic [7:0] short_count_out,
  input logic cfg_err_out,
  input logic running_out
);
  // ****
  // properties
  // ****
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  chk_cfg_refused: assert property (dc_sync_in && (os_factor_in == 10'h000
    || os_factor_in > MAX_BLOCKS) |=> cfg_err_out && !running_out) else $error("cfg");
  chk_wait_no_seal: assert property (!running_out |=> $stable(set_blocks_out))
    else $error("seal");
  chk_set_stands: assert property (!dc_sync_in |=> $stable(set_ready_out))
    else $error("stand");
  chk_ready_excl: assert property (set_ready_out |-> !set_short_out && set_blocks_out != 8'h00)
    else $error("excl");
  chk_short_tally: assert property ($changed(short_count_out) |-> set_short_out
    && short_count_out == $past(short_count_out) + 8'h01) else $error("tally");
  chk_run_on_sync: assert property ($rose(running_out) |-> $past(dc_sync_in))
    else $error("start");
  chk_fetch_answer: assert property (fetch_req_in |=> fetch_valid_out)
    else $error("answer");
  chk_fetch_quiet: assert property (!fetch_req_in |=> !fetch_valid_out)
    else $error("stray");
  chk_fetch_beyond: assert property (fetch_req_in && fetch_addr_in >= set_blocks_out
    |=> fetch_data_out == 8'h00) else $error("beyond");
  chk_pad_zero: assert property (fetch_valid_out |-> fetch_data_out[7:2] == 6'h00)
    else $error("pad");
endmodule // odic_chk

bind odic_capture_top odic_chk #(.MAX_BLOCKS(MAX_BLOCKS)) odic_chk_i (.core_clk_in, .rst_in,
  .dc_sync_in, .os_factor_in, .fetch_req_in, .fetch_addr_in, .fetch_data_out,
  .fetch_valid_out, .set_ready_out, .set_short_out, .set_blocks_out, .short_count_out, .cfg_err_out,
  .running_out);

/* tb/odic_fsc_model.sv */
// slave controller model fetching the sealed set
`timescale 1ns/1ps
module odic_fsc_model (
  // clock and frame command
  input logic core_clk_in,
  input logic go_in,
  input logic slow_in,
  // fetch port
  output logic fetch_req_out,
  output logic [7:0] fetch_addr_out,
  input logic [7:0] fetch_data_in,
  input logic fetch_valid_in,
  // collected image
  output logic [7:0] image_out [8],
  output logic busy_out
);
  logic [7:0] last;
  int i;
  initial begin
    fetch_req_out = 1'b0;
    fetch_addr_out = 8'h5A;
    busy_out = 1'b0;
    forever begin
      @(posedge core_clk_in);
      if (go_in) begin
        busy_out = 1'b1;
        for (i = 0; i < 5; i++) begin
          @(negedge core_clk_in);
          fetch_req_out = 1'b1;
          fetch_addr_out = i[7:0];
          if (slow_in) begin
            @(negedge core_clk_in);
            fetch_req_out = 1'b0;
            fetch_addr_out = ~fetch_addr_out;
          end
        end
        @(negedge core_clk_in);
        fetch_req_out = 1'b0;
        // idle address toggles so stale values never look valid
        fetch_addr_out = ~fetch_addr_out;
        // busy drops on a rising edge so the bench never races it at the falling one
        @(posedge core_clk_in);
        busy_out = 1'b0;
      end
    end
  end
  always @(posedge core_clk_in) begin
    if (go_in) image_out <= '{default: 8'hEE};
    else if (fetch_valid_in) image_out[last[2:0]] <= fetch_data_in;
    last <= fetch_addr_out;
  end
endmodule // odic_fsc_model

/* tb/testbench.sv */
// self-checking bench for the capture block
`timescale 1ns/1ps
module testbench;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic dc_sync_in = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [1:0] chan_in = 2'h1;
  logic [31:0] dc_time_in = 32'hFFFF_F000;
  logic [9:0] os_factor_in = 10'h004;
  logic [31:0] sub_period_in = 32'h0000_03E8;
  logic fetch_req_in, fetch_valid_out, set_ready_out, set_short_out, cfg_err_out, running_out;
  logic busy;
  logic [7:0] fetch_addr_in, fetch_data_out, set_blocks_out, short_count_out;
  logic [7:0] image [8];
  logic [1:0] pat [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [41:0] cfgs [4] = '{{10'h000, 32'h0000_03E8}, {10'h0FF, 32'h0000_03E8},
    {10'h004, 32'h0000_03E7}, {10'h0FE, 32'h0000_03E8}};
  int errors = 0;
  int checked = 0;
  // ****
  // clock, time base, instances
  // ****
  always #25 core_clk_in = ~core_clk_in;
  // starts near the top so the time base wraps mid-run
  always @(negedge core_clk_in) dc_time_in <= dc_time_in + 32'h0000_0032;
  odic_capture_top odic_capture_top_i (.core_clk_in, .rst_in, .chan_in, .dc_time_in,
    .dc_sync_in, .os_factor_in, .sub_period_in, .fetch_req_in, .fetch_addr_in,
    .fetch_data_out, .fetch_valid_out, .set_ready_out, .set_blocks_out, .set_short_out,
    .short_count_out, .cfg_err_out, .running_out);
  odic_fsc_model odic_fsc_model_i (.core_clk_in, .go_in(go), .slow_in(slow),
    .fetch_req_out(fetch_req_in), .fetch_addr_out(fetch_addr_in),
    .fetch_data_in(fetch_data_out), .fetch_valid_in(fetch_valid_out), .image_out(image),
    .busy_out(busy));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic sync;
    dc_sync_in = 1'b1;
    @(negedge core_clk_in);
    dc_sync_in = 1'b0;
    @(negedge core_clk_in);
  endtask
  task automatic run(input int cyc);
    for (int c = 0; c < cyc; c++) begin
      chan_in = pat[((c + 10) / 20) % 4];
      @(negedge core_clk_in);
    end
  endtask
  task automatic fetch(input logic s, input int blocks);
    slow = s;
    go = 1'b1;
    @(negedge core_clk_in);
    go = 1'b0;
    for (int k = 0; k < 40 && busy !== 1'b0; k++) @(negedge core_clk_in);
    if (busy !== 1'b0) begin
      errors++;
      results();
    end
    @(negedge core_clk_in);
    for (int k = 0; k < 5; k++) check(image[k], k < blocks ? {6'h00, pat[k % 4]} : 8'h00);
  endtask
  task automatic t_full;
    sync();
    run(75);
    sync();
    check({set_ready_out, set_short_out, cfg_err_out, running_out}, 8'h09);
    check(set_blocks_out, 8'h04);
    fetch(1'b0, 4);
    fetch(1'b1, 4);
    $display("full done");
  endtask
  task automatic t_short;
    run(60);
    sync();
    run(28);
    sync();
    check({set_ready_out, set_short_out, short_count_out[1:0]}, 8'h05);
    check(set_blocks_out, 8'h02);
    $display("short done");
  endtask
  task automatic t_cfg;
    for (int k = 0; k < 4; k++) begin
      {os_factor_in, sub_period_in} = cfgs[k];
      sync();
      check({cfg_err_out, running_out}, k < 3 ? 8'h02 : 8'h01);
    end
    $display("cfg done");
  endtask
  initial begin
    repeat (8) @(negedge core_clk_in);
    rst_in = 1'b0;
    t_full();
    t_short();
    t_cfg();
    results();
  end
endmodule // testbench
